// file: core/spm_core.sv
// Pass-through and mirror control for a 64-byte buffer shared by RF and host sides.
// Assumes a register port from the host and one-cycle page requests from the RF logic.
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/1ps
module spm_core
    import spm_pkg::*;
(
    input  wire logic        REF_CLK_IN,
    input  wire logic        RESET_IN,
    input  wire logic [7:0]  ADDR_IN,
    input  wire logic [31:0] WDATA_IN,
    input  wire logic        WR_IN,
    input  wire logic        RD_IN,
    output logic      [31:0] RDATA_OUT,
    input  wire logic        RF_FIELD_IN,
    input  wire logic        HOST_PWR_IN,
    input  wire logic        RF_REQ_IN,
    input  wire logic        RF_WR_IN,
    input  wire logic        RF_BULK_IN,
    input  wire logic        RF_AUTH_IN,
    input  wire logic [1:0]  RF_SECTOR_IN,
    input  wire logic [7:0]  RF_PAGE_IN,
    input  wire logic [31:0] RF_WDATA_IN,
    output logic             RF_ACK_OUT,
    output logic             RF_NAK_OUT,
    output logic             RF_FWD_OUT,
    output logic      [31:0] RF_RDATA_OUT,
    output logic             PASSTHROUGH_OUT,
    output logic             MIRROR_OUT,
    output logic             HOST_OWNS_OUT
);
    // Region of an RF page
    function automatic spm_region_t rf_region(input logic [1:0] sec, input logic [7:0] pg,
                                              input logic pt, input logic mir,
                                              input logic [7:0] base);
        logic [7:0] rel;
        rel = pg - base;
        if (sec == SPM_SECTOR0) begin
            if (pt && pg >= SPM_PG_BUF_LO) return SPM_RG_BUF;
            if (mir && pg >= base && rel < 8'(SPM_BUF_WORDS)) return SPM_RG_BUF;
            if (pg <= SPM_PG_EE_LAST) return SPM_RG_FWD;
            if (pg == SPM_PG_CFG0) return SPM_RG_CFG;
            if (pg == SPM_PG_CFG1) return SPM_RG_PROT;
            if (pg == SPM_PG_SES0) return SPM_RG_SES;
            if (pg == SPM_PG_SES1) return SPM_RG_SMIR;
            return SPM_RG_NAK;
        end
        if (sec == SPM_SECTOR1) return SPM_RG_FWD;
        if (sec == SPM_SECTOR3 && pg == SPM_PG_S3_SES0) return SPM_RG_SES;
        if (sec == SPM_SECTOR3 && pg == SPM_PG_S3_SES1) return SPM_RG_SMIR;
        return SPM_RG_NAK;
    endfunction : rf_region

    // Power pins: three flops, accepted once stages two and three agree
    logic [2:0] rf_sync_r;
    logic [2:0] host_sync_r;
    logic       rf_pwr_r;
    logic       host_pwr_r;

    always_ff @(posedge REF_CLK_IN) begin
        rf_sync_r   <= {rf_sync_r[1:0], RF_FIELD_IN};
        host_sync_r <= {host_sync_r[1:0], HOST_PWR_IN};
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (RESET_IN) begin
            rf_pwr_r   <= 1'b0;
            host_pwr_r <= 1'b0;
        end else begin
            if (rf_sync_r[1] == rf_sync_r[2]) rf_pwr_r <= rf_sync_r[2];
            if (host_sync_r[1] == host_sync_r[2]) host_pwr_r <= host_sync_r[2];
        end
    end

    logic both_pwr;
    assign both_pwr = rf_pwr_r & host_pwr_r;

    // Control state
    logic       pt_en_r;
    logic       dir_r;
    logic       mirror_r;
    logic [7:0] mirror_pg_r;
    logic       cfg_dir_r;
    logic       cfg_mirror_r;
    logic       buf_prot_r;
    logic [7:0] prot_pg_r;
    logic       owner_r;
    logic       bulk_r;
    logic [3:0] bulk_idx_r;

    logic pt_act;
    logic mir_act;
    assign pt_act  = pt_en_r;
    assign mir_act = mirror_r & ~pt_en_r & host_pwr_r;

    // Host decode
    logic           h_buf;
    logic [3:0]     h_idx;
    logic           h_buf_ok;
    assign h_buf    = ADDR_IN[7:6] == SPM_OFF_BUF_BASE[7:6];
    assign h_idx    = ADDR_IN[5:2];
    assign h_buf_ok = h_buf & (mir_act | (pt_act & owner_r == SPM_OWN_HOST));

    // RF decode
    spm_region_t rf_rg;
    logic [3:0]  rf_idx;
    logic        rf_auth_ok;
    logic        rf_buf_ok;
    logic        rf_bulk_step;
    logic        rf_wr_buf;
    assign rf_rg        = rf_region(RF_SECTOR_IN, RF_PAGE_IN, pt_act, mir_act, mirror_pg_r);
    assign rf_auth_ok   = ~(buf_prot_r & prot_pg_r != SPM_PG_AUTH_OFF) | RF_AUTH_IN;
    assign rf_bulk_step = bulk_r & RF_REQ_IN & RF_WR_IN;
    assign rf_buf_ok    = rf_rg == SPM_RG_BUF & rf_auth_ok
                          & (mir_act | owner_r == SPM_OWN_RF)
                          & ~(mir_act & WR_IN & h_buf & RF_WR_IN);
    assign rf_idx       = rf_bulk_step ? bulk_idx_r
                        : pt_act ? RF_PAGE_IN[3:0] : 4'(RF_PAGE_IN - mirror_pg_r);

    // Buffer memory; host write wins a mirror-mode collision
    logic        mem_we;
    logic [3:0]  mem_waddr;
    logic [31:0] mem_wdata;
    logic [31:0] mem_rf_q;
    logic [31:0] mem_host_q;
    assign rf_wr_buf = rf_bulk_step | (RF_REQ_IN & RF_WR_IN & rf_buf_ok);
    assign mem_we    = (WR_IN & h_buf_ok) | rf_wr_buf;
    assign mem_waddr = (WR_IN & h_buf_ok) ? h_idx : rf_idx;
    assign mem_wdata = (WR_IN & h_buf_ok) ? WDATA_IN : RF_WDATA_IN;

    spm_ram #(.WORDS(SPM_BUF_WORDS), .AW(SPM_BUF_AW), .DW(32)) u_ram (
        .clk_in      (REF_CLK_IN),
        .we_in       (mem_we),
        .waddr_in    (mem_waddr),
        .wdata_in    (mem_wdata),
        .raddr_a_in  (rf_idx),
        .raddr_b_in  (h_idx),
        .rdata_a_out (mem_rf_q),
        .rdata_b_out (mem_host_q)
    );

    logic [31:0] ses_word;
    logic [31:0] cfg_word;
    logic [31:0] prot_word;
    logic [31:0] mir_word;
    always_comb begin
        ses_word = '0;
        ses_word[SPM_BIT_PT_EN]    = pt_en_r;
        ses_word[SPM_BIT_DIR]      = dir_r;
        ses_word[SPM_BIT_MIRROR]   = mirror_r;
        ses_word[SPM_BIT_OWNER]    = owner_r;
        ses_word[SPM_BIT_RF_PWR]   = rf_pwr_r;
        ses_word[SPM_BIT_HOST_PWR] = host_pwr_r;
        cfg_word = '0;
        cfg_word[SPM_BIT_DIR]      = cfg_dir_r;
        cfg_word[SPM_BIT_MIRROR]   = cfg_mirror_r;
        prot_word = '0;
        prot_word[SPM_BIT_BUF_PROT] = buf_prot_r;
        prot_word[SPM_POS_PROT_PG +: 8] = prot_pg_r;
        mir_word = {24'h00_0000, mirror_pg_r};
    end

    // Terminator handover
    logic h_term;
    logic rf_term;
    assign h_term  = (WR_IN | RD_IN) & h_buf_ok & pt_act & h_idx == 4'hF;
    assign rf_term = pt_act & ((rf_bulk_step & bulk_idx_r == 4'hF)
                     | (RF_REQ_IN & ~bulk_r & rf_buf_ok & RF_PAGE_IN == SPM_PG_BUF_HI));

    always_ff @(posedge REF_CLK_IN) begin
        if (RESET_IN) begin
            owner_r <= SPM_OWN_RF;
        end else if (!pt_act) begin
            owner_r <= dir_r ? SPM_OWN_RF : SPM_OWN_HOST;
        end else if (h_term && owner_r == SPM_OWN_HOST) begin
            owner_r <= SPM_OWN_RF;
        end else if (rf_term && owner_r == SPM_OWN_RF) begin
            owner_r <= SPM_OWN_HOST;
        end
    end

    // Session register: enable, direction, mirror
    logic rf_ses_wr;
    logic h_ses_wr;
    assign rf_ses_wr = RF_REQ_IN & RF_WR_IN & ~bulk_r & rf_rg == SPM_RG_SES;
    assign h_ses_wr  = WR_IN & ADDR_IN == SPM_OFF_SESSION;

    always_ff @(posedge REF_CLK_IN) begin
        if (RESET_IN) begin
            pt_en_r <= 1'b0;
        end else if (!both_pwr) begin
            pt_en_r <= 1'b0;
        end else if (h_ses_wr) begin
            pt_en_r <= WDATA_IN[SPM_BIT_PT_EN];
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (RESET_IN) begin
            dir_r    <= SPM_RST_DIR;
            mirror_r <= SPM_RST_MIRROR;
        end else if (h_ses_wr) begin
            dir_r    <= WDATA_IN[SPM_BIT_DIR];
            mirror_r <= WDATA_IN[SPM_BIT_MIRROR];
        end else if (rf_ses_wr) begin
            mirror_r <= RF_WDATA_IN[SPM_BIT_MIRROR];
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (RESET_IN) begin
            mirror_pg_r <= SPM_RST_MIRROR_PG;
        end else if (WR_IN && ADDR_IN == SPM_OFF_MIRROR) begin
            mirror_pg_r <= WDATA_IN[7:0];
        end else if (RF_REQ_IN && RF_WR_IN && !bulk_r && rf_rg == SPM_RG_SMIR) begin
            mirror_pg_r <= RF_WDATA_IN[7:0];
        end
    end

    // Configuration defaults and protection, writable from both sides
    always_ff @(posedge REF_CLK_IN) begin
        if (RESET_IN) begin
            cfg_dir_r    <= SPM_RST_DIR;
            cfg_mirror_r <= SPM_RST_MIRROR;
        end else if (WR_IN && ADDR_IN == SPM_OFF_CONFIG) begin
            cfg_dir_r    <= WDATA_IN[SPM_BIT_DIR];
            cfg_mirror_r <= WDATA_IN[SPM_BIT_MIRROR];
        end else if (RF_REQ_IN && RF_WR_IN && !bulk_r && rf_rg == SPM_RG_CFG) begin
            cfg_dir_r    <= RF_WDATA_IN[SPM_BIT_DIR];
            cfg_mirror_r <= RF_WDATA_IN[SPM_BIT_MIRROR];
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (RESET_IN) begin
            buf_prot_r <= 1'b0;
            prot_pg_r  <= SPM_RST_PROT_PG;
        end else if (WR_IN && ADDR_IN == SPM_OFF_PROTECT) begin
            buf_prot_r <= WDATA_IN[SPM_BIT_BUF_PROT];
            prot_pg_r  <= WDATA_IN[SPM_POS_PROT_PG +: 8];
        end else if (RF_REQ_IN && RF_WR_IN && !bulk_r && rf_rg == SPM_RG_PROT) begin
            buf_prot_r <= RF_WDATA_IN[SPM_BIT_BUF_PROT];
            prot_pg_r  <= RF_WDATA_IN[SPM_POS_PROT_PG +: 8];
        end
    end

    // Bulk write: opening request carries word 0, next fifteen requests the rest
    always_ff @(posedge REF_CLK_IN) begin
        if (RESET_IN) begin
            bulk_r     <= 1'b0;
            bulk_idx_r <= 4'h0;
        end else if (bulk_r) begin
            if (!pt_act && !mir_act) begin
                bulk_r <= 1'b0;
            end else if (rf_bulk_step) begin
                bulk_idx_r <= bulk_idx_r + 4'h1;
                bulk_r     <= bulk_idx_r != 4'hF;
            end
        end else if (RF_REQ_IN && RF_WR_IN && RF_BULK_IN && rf_buf_ok) begin
            bulk_r     <= 1'b1;
            bulk_idx_r <= 4'h1;
        end
    end

    // RF answer, one cycle after the request
    logic        rf_ack_r;
    logic        rf_nak_r;
    logic        rf_fwd_r;
    logic        rf_mem_sel_r;
    logic [31:0] rf_reg_q_r;

    always_ff @(posedge REF_CLK_IN) begin
        if (RESET_IN) begin
            rf_ack_r     <= 1'b0;
            rf_nak_r     <= 1'b0;
            rf_fwd_r     <= 1'b0;
            rf_mem_sel_r <= 1'b0;
            rf_reg_q_r   <= 32'h0000_0000;
        end else begin
            rf_ack_r     <= 1'b0;
            rf_nak_r     <= 1'b0;
            rf_fwd_r     <= 1'b0;
            rf_mem_sel_r <= 1'b0;
            rf_reg_q_r   <= 32'h0000_0000;
            if (rf_bulk_step) begin
                rf_ack_r <= 1'b1;
            end else if (RF_REQ_IN) begin
                case (rf_rg)
                    SPM_RG_BUF: begin
                        rf_ack_r     <= rf_buf_ok;
                        rf_nak_r     <= ~rf_buf_ok;
                        rf_mem_sel_r <= rf_buf_ok & ~RF_WR_IN;
                    end
                    SPM_RG_FWD: rf_fwd_r <= 1'b1;
                    SPM_RG_SES: begin
                        rf_ack_r   <= 1'b1;
                        rf_reg_q_r <= ses_word;
                    end
                    SPM_RG_SMIR: begin
                        rf_ack_r   <= 1'b1;
                        rf_reg_q_r <= mir_word;
                    end
                    SPM_RG_CFG: begin
                        rf_ack_r   <= 1'b1;
                        rf_reg_q_r <= cfg_word;
                    end
                    SPM_RG_PROT: begin
                        rf_ack_r   <= 1'b1;
                        rf_reg_q_r <= prot_word;
                    end
                    default: rf_nak_r <= 1'b1;
                endcase
            end
        end
    end

    assign RF_ACK_OUT   = rf_ack_r;
    assign RF_NAK_OUT   = rf_nak_r;
    assign RF_FWD_OUT   = rf_fwd_r;
    assign RF_RDATA_OUT = rf_mem_sel_r ? mem_rf_q : rf_reg_q_r;

    // Host read data, one cycle after the read strobe
    logic        h_mem_sel_r;
    logic [31:0] h_reg_q_r;
    always_ff @(posedge REF_CLK_IN) begin
        if (RESET_IN) begin
            h_mem_sel_r <= 1'b0;
            h_reg_q_r   <= 32'h0000_0000;
        end else begin
            h_mem_sel_r <= RD_IN & h_buf_ok;
            case (ADDR_IN)
                SPM_OFF_SESSION: h_reg_q_r <= RD_IN ? ses_word : 32'h0000_0000;
                SPM_OFF_CONFIG:  h_reg_q_r <= RD_IN ? cfg_word : 32'h0000_0000;
                SPM_OFF_MIRROR:  h_reg_q_r <= RD_IN ? mir_word : 32'h0000_0000;
                SPM_OFF_PROTECT: h_reg_q_r <= RD_IN ? prot_word : 32'h0000_0000;
                default:         h_reg_q_r <= 32'h0000_0000;
            endcase
        end
    end

    assign RDATA_OUT       = h_mem_sel_r ? mem_host_q : h_reg_q_r;
    assign PASSTHROUGH_OUT = pt_en_r;
    assign MIRROR_OUT      = mir_act;
    assign HOST_OWNS_OUT   = owner_r;

    // Checks
    property p_pt_report;
        @(posedge REF_CLK_IN) disable iff (RESET_IN)
        (RD_IN && ADDR_IN == SPM_OFF_SESSION)
        |=> RDATA_OUT[SPM_BIT_PT_EN] == $past(PASSTHROUGH_OUT);
    endproperty
    a_pt_report: assert property (p_pt_report) else $error("Enable bit misreported");

    property p_auth;
        @(posedge REF_CLK_IN) disable iff (RESET_IN)
        (RF_REQ_IN && !bulk_r && rf_rg == SPM_RG_BUF && buf_prot_r
         && prot_pg_r != SPM_PG_AUTH_OFF && !RF_AUTH_IN) |=> RF_NAK_OUT && !RF_ACK_OUT;
    endproperty
    a_auth: assert property (p_auth) else $error("Unauthenticated buffer access");

    property p_map;
        @(posedge REF_CLK_IN) disable iff (RESET_IN)
        (PASSTHROUGH_OUT && RF_SECTOR_IN == SPM_SECTOR0 && RF_PAGE_IN >= SPM_PG_BUF_LO)
        |-> rf_rg == SPM_RG_BUF;
    endproperty
    a_map: assert property (p_map) else $error("Buffer not at F0h-FFh");

    property p_dir_rf;
        @(posedge REF_CLK_IN) disable iff (RESET_IN)
        (!h_ses_wr) |=> dir_r == $past(dir_r);
    endproperty
    a_dir_rf: assert property (p_dir_rf) else $error("Direction changed without host");

    property p_enable;
        @(posedge REF_CLK_IN) disable iff (RESET_IN)
        $rose(pt_en_r) |-> $past(h_ses_wr) && $past(both_pwr);
    endproperty
    a_enable: assert property (p_enable) else $error("Illegal pass-through enable");

    property p_power_loss;
        @(posedge REF_CLK_IN) disable iff (RESET_IN)
        (!rf_pwr_r || !host_pwr_r) |=> !PASSTHROUGH_OUT;
    endproperty
    a_power_loss: assert property (p_power_loss) else $error("Mode kept without power");

    property p_handover;
        @(posedge REF_CLK_IN) disable iff (RESET_IN)
        (pt_act && rf_term && owner_r == SPM_OWN_RF && !h_term) |=> HOST_OWNS_OUT;
    endproperty
    a_handover: assert property (p_handover) else $error("No handover at terminator");

    property p_exclusive;
        @(posedge REF_CLK_IN) disable iff (RESET_IN)
        !(MIRROR_OUT && PASSTHROUGH_OUT)
        && !(PASSTHROUGH_OUT && RF_SECTOR_IN == SPM_SECTOR0 && RF_PAGE_IN < SPM_PG_BUF_LO
             && rf_rg == SPM_RG_BUF);
    endproperty
    a_exclusive: assert property (p_exclusive) else $error("Mirror with pass-through");

    property p_unmapped;
        @(posedge REF_CLK_IN) disable iff (RESET_IN)
        (RF_REQ_IN && !bulk_r && RF_SECTOR_IN == 2'h2) |=> RF_NAK_OUT;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("Sector 2 not refused");

    property p_lock;
        @(posedge REF_CLK_IN) disable iff (RESET_IN)
        (WR_IN && h_buf && PASSTHROUGH_OUT && !HOST_OWNS_OUT)
        |-> !mem_we || (mem_waddr == rf_idx && mem_wdata == RF_WDATA_IN);
    endproperty
    a_lock: assert property (p_lock) else $error("Host wrote buffer it does not own");
endmodule : spm_core

// file: core/spm_pkg.sv
// Package for the pass-through buffer mapping block: offsets, fields, pages, resets.
// Assumes a 32-bit register port on the host side and page-wide RF accesses.
package spm_pkg;

    // Host register offsets (byte addresses)
    localparam logic [7:0] SPM_OFF_SESSION  = 8'h00;
    localparam logic [7:0] SPM_OFF_CONFIG   = 8'h04;
    localparam logic [7:0] SPM_OFF_MIRROR   = 8'h08;
    localparam logic [7:0] SPM_OFF_PROTECT  = 8'h0C;
    localparam logic [7:0] SPM_OFF_BUF_BASE = 8'h40;

    // Session and configuration word fields
    localparam int SPM_BIT_PT_EN    = 0;
    localparam int SPM_BIT_DIR      = 1;
    localparam int SPM_BIT_MIRROR   = 2;
    localparam int SPM_BIT_OWNER    = 4;
    localparam int SPM_BIT_RF_PWR   = 5;
    localparam int SPM_BIT_HOST_PWR = 6;

    // Protection word fields
    localparam int SPM_BIT_BUF_PROT = 0;
    localparam int SPM_POS_PROT_PG  = 8;

    // Reset values
    localparam logic       SPM_RST_DIR       = 1'b1;
    localparam logic       SPM_RST_MIRROR    = 1'b0;
    localparam logic [7:0] SPM_RST_MIRROR_PG = 8'h01;
    localparam logic [7:0] SPM_RST_PROT_PG   = 8'hFF;

    // RF page map
    localparam logic [1:0] SPM_SECTOR0     = 2'h0;
    localparam logic [1:0] SPM_SECTOR1     = 2'h1;
    localparam logic [1:0] SPM_SECTOR3     = 2'h3;
    localparam logic [7:0] SPM_PG_EE_LAST  = 8'hE7;
    localparam logic [7:0] SPM_PG_CFG0     = 8'hE8;
    localparam logic [7:0] SPM_PG_CFG1     = 8'hE9;
    localparam logic [7:0] SPM_PG_SES0     = 8'hEC;
    localparam logic [7:0] SPM_PG_SES1     = 8'hED;
    localparam logic [7:0] SPM_PG_BUF_LO   = 8'hF0;
    localparam logic [7:0] SPM_PG_BUF_HI   = 8'hFF;
    localparam logic [7:0] SPM_PG_S3_SES0  = 8'hF8;
    localparam logic [7:0] SPM_PG_S3_SES1  = 8'hF9;
    localparam logic [7:0] SPM_PG_AUTH_OFF = 8'hFF;

    // Buffer geometry
    localparam int SPM_BUF_BYTES = 64;
    localparam int SPM_BUF_WORDS = SPM_BUF_BYTES / 4;
    localparam int SPM_BUF_AW    = 4;

    // Owner of the pass-through buffer
    localparam logic SPM_OWN_RF   = 1'b0;
    localparam logic SPM_OWN_HOST = 1'b1;

    typedef enum {
        SPM_RG_NAK,
        SPM_RG_FWD,
        SPM_RG_SES,
        SPM_RG_SMIR,
        SPM_RG_CFG,
        SPM_RG_PROT,
        SPM_RG_BUF
    } spm_region_t;

endpackage : spm_pkg

// file: core/spm_ram.sv
// Small buffer memory: one write port, two registered read ports.
// Assumes the caller resolves write collisions before the write port.
`timescale 1ns/1ps
module spm_ram #(
    parameter int WORDS = 16,
    parameter int AW    = 4,
    parameter int DW    = 32
) (
    input  wire logic          clk_in,
    input  wire logic          we_in,
    input  wire logic [AW-1:0] waddr_in,
    input  wire logic [DW-1:0] wdata_in,
    input  wire logic [AW-1:0] raddr_a_in,
    input  wire logic [AW-1:0] raddr_b_in,
    output logic      [DW-1:0] rdata_a_out,
    output logic      [DW-1:0] rdata_b_out
);
    logic [DW-1:0] mem [WORDS];

    always_ff @(posedge clk_in) begin
        if (we_in) begin
            mem[waddr_in] <= wdata_in;
        end
    end

    always_ff @(posedge clk_in) begin
        rdata_a_out <= mem[raddr_a_in];
        rdata_b_out <= mem[raddr_b_in];
    end
endmodule : spm_ram

// file: test/spm_far_side.sv
// RF reader model: page requests plus field and authentication levels.
// Assumes the core takes a request at a rising edge and answers next cycle.
`timescale 1ns/1ps
module spm_far_side (
    input  wire logic        clk_in,
    input  wire logic        ack_in,
    input  wire logic        nak_in,
    input  wire logic        fwd_in,
    output logic             field_out,
    output logic             auth_out,
    output logic             req_out,
    output logic             wr_out,
    output logic             bulk_out,
    output logic      [1:0]  sector_out,
    output logic      [7:0]  page_out,
    output logic      [31:0] wdata_out
);
    initial begin
        {req_out, wr_out, bulk_out, auth_out, sector_out, page_out} = '0;
        field_out = 1'b1;
        wdata_out = 32'h0000_0000;
    end
    task automatic set_lv(input logic f, input logic a);
        @(posedge clk_in);
        {field_out, auth_out} <= {f, a};
    endtask : set_lv
    task automatic rf(input logic w, input logic b, input logic [1:0] s,
                      input logic [7:0] p, input logic [31:0] d, output logic [2:0] r);
        @(posedge clk_in);
        {req_out, wr_out, bulk_out, sector_out, page_out, wdata_out} <= {1'b1, w, b, s, p, d};
        @(posedge clk_in);
        req_out   <= 1'b0;
        // Released data line shows the inverse
        wdata_out <= ~d;
        #1 r = {ack_in, nak_in, fwd_in};
    endtask : rf
endmodule : spm_far_side

// file: test/tb_top.sv
// Self-checking bench for spm_core: host register tasks and RF reader model.
// Assumes one-cycle answers on both the host port and the RF port.
`timescale 1ns/1ps
module tb_top
    import spm_pkg::*;
;
    logic        clk, rst, wr, rd, hpwr, field, auth, req, rwr, bulk;
    logic        ack, nak, fwd, pt, mir, howns;
    logic [1:0]  sec;
    logic [7:0]  addr, page;
    logic [31:0] wdata, rdata, rwdata, rrdata;
    logic [2:0]  r;
    int          bad_count = 0;
    int          checks = 0;
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    spm_core u_spm_core (.REF_CLK_IN(clk), .RESET_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata),
        .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .RF_FIELD_IN(field), .HOST_PWR_IN(hpwr),
        .RF_REQ_IN(req), .RF_WR_IN(rwr), .RF_BULK_IN(bulk), .RF_AUTH_IN(auth),
        .RF_SECTOR_IN(sec), .RF_PAGE_IN(page), .RF_WDATA_IN(rwdata), .RF_ACK_OUT(ack),
        .RF_NAK_OUT(nak), .RF_FWD_OUT(fwd), .RF_RDATA_OUT(rrdata), .PASSTHROUGH_OUT(pt),
        .MIRROR_OUT(mir), .HOST_OWNS_OUT(howns));
    spm_far_side u_spm_far_side (.clk_in(clk), .ack_in(ack), .nak_in(nak), .fwd_in(fwd),
        .field_out(field), .auth_out(auth), .req_out(req), .wr_out(rwr), .bulk_out(bulk),
        .sector_out(sec), .page_out(page), .wdata_out(rwdata));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic hw(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {wr, addr, wdata} <= {1'b1, a, d};
        @(posedge clk);
        wr <= 1'b0;
    endtask : hw
    task automatic hr(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        {rd, addr} <= {1'b1, a};
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask : hr
    task automatic rq(input logic w, input logic b, input logic [1:0] s,
                      input logic [7:0] p, input logic [31:0] d, input logic [2:0] e);
        u_spm_far_side.rf(w, b, s, p, d, r);
        chk({29'h0, r}, {29'h0, e});
    endtask : rq
    task automatic end_of_test;
        if (bad_count == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test
    initial begin
        #1_000_000;
        bad_count++;
        end_of_test();
    end
    initial begin
        {rst, wr, rd, addr, wdata} = {1'b1, 42'h0};
        hpwr = 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (5) @(posedge clk);
        hr(SPM_OFF_SESSION, 32'h0000_0062);
        hw(SPM_OFF_SESSION, 32'h0000_0003);
        hr(SPM_OFF_SESSION, 32'h0000_0063);
        rq(1, 0, SPM_SECTOR0, SPM_PG_SES0, 32'h0, 3'b100);
        hr(SPM_OFF_SESSION, 32'h0000_0063);
        rq(1, 1, SPM_SECTOR0, SPM_PG_BUF_LO, 32'hA5A5_0000, 3'b100);
        for (int i = 1; i < 16; i++) begin
            rq(1, 0, SPM_SECTOR0, 8'(SPM_PG_BUF_LO + i), 32'hA5A5_0000 + i, 3'b100);
        end
        chk({31'h0, howns}, 32'h1);
        for (int i = 0; i < 16; i++) begin
            hr(8'(SPM_OFF_BUF_BASE + 4 * i), 32'hA5A5_0000 + i);
        end
        chk({31'h0, howns}, 32'h0);
        rq(0, 0, SPM_SECTOR0, SPM_PG_BUF_HI, 32'h0, 3'b100);
        chk(rrdata, 32'hA5A5_000F);
        rq(0, 0, SPM_SECTOR0, SPM_PG_BUF_LO, 32'h0, 3'b010);
        rq(0, 0, 2'h2, 8'h10, 32'h0, 3'b010);
        rq(0, 0, SPM_SECTOR0, 8'hEA, 32'h0, 3'b010);
        rq(0, 0, SPM_SECTOR3, 8'h00, 32'h0, 3'b010);
        rq(0, 0, SPM_SECTOR1, 8'h05, 32'h0, 3'b001);
        rq(0, 0, SPM_SECTOR3, SPM_PG_S3_SES0, 32'h0, 3'b100);
        chk(rrdata, 32'h0000_0073);
        rq(1, 0, SPM_SECTOR0, SPM_PG_CFG0, 32'h0000_0002, 3'b100);
        hr(SPM_OFF_CONFIG, 32'h0000_0002);
        hw(SPM_OFF_CONFIG, 32'h0000_0000);
        hr(SPM_OFF_CONFIG, 32'h0000_0000);
        hw(SPM_OFF_SESSION, 32'h0000_0007);
        #1 chk({30'h0, mir, pt}, 32'h1);
        u_spm_far_side.set_lv(1'b0, 1'b0);
        repeat (6) @(posedge clk);
        #1 chk({31'h0, pt}, 32'h0);
        hw(SPM_OFF_SESSION, 32'h0000_0003);
        hr(SPM_OFF_SESSION, 32'h0000_0042);
        u_spm_far_side.set_lv(1'b1, 1'b0);
        repeat (6) @(posedge clk);
        hw(SPM_OFF_SESSION, 32'h0000_0003);
        hw(SPM_OFF_PROTECT, 32'h0000_0001);
        rq(0, 0, SPM_SECTOR0, SPM_PG_BUF_LO, 32'h0, 3'b010);
        u_spm_far_side.set_lv(1'b1, 1'b1);
        rq(0, 0, SPM_SECTOR0, SPM_PG_BUF_LO, 32'h0, 3'b100);
        hw(SPM_OFF_SESSION, 32'h0000_0004);
        #1 chk({30'h0, mir, pt}, 32'h2);
        rq(1, 0, SPM_SECTOR0, 8'h01, 32'h5A5A_0001, 3'b100);
        hr(SPM_OFF_BUF_BASE, 32'h5A5A_0001);
        hw(SPM_OFF_MIRROR, 32'h0000_0020);
        rq(0, 0, SPM_SECTOR0, 8'h20, 32'h0, 3'b100);
        chk(rrdata, 32'h5A5A_0001);
        rq(0, 0, SPM_SECTOR0, 8'h01, 32'h0, 3'b001);
        end_of_test();
    end
endmodule : tb_top
